// ==== hw/sadc_pkg.sv ====
package sadc_pkg;
    // local clock
    localparam int CLK_PERIOD_NS     = 40;
    // word layout: sign plus fourteen magnitude bits, two's complement
    localparam int WORD_BITS         = 15;
    localparam int WORD_MSB          = WORD_BITS - 1;
    // conversion time, least, rounded up
    localparam int CONV_TIME_NS      = 220;
    localparam int CONV_CYC          = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // shift quiet time after start fall, least, rounded up
    localparam int SHIFT_QUIET_AFTER_START_NS = 220;
    localparam int QUIET_CYC         = (SHIFT_QUIET_AFTER_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // drive and release delays, longest, rounded down, floor of one cycle
    localparam int OUTPUT_DRIVE_DELAY_NS   = 5;
    localparam int DRIVE_CYC         = (OUTPUT_DRIVE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                       OUTPUT_DRIVE_DELAY_NS / CLK_PERIOD_NS;
    localparam int OUTPUT_RELEASE_DELAY_NS = 5;
    localparam int RELEASE_CYC       = (OUTPUT_RELEASE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                       OUTPUT_RELEASE_DELAY_NS / CLK_PERIOD_NS;
    // last shift fall to start rise, least
    localparam int LAST_SHIFT_TO_START_HIGH_NS = 0;
    localparam int LAST_CYC          = (LAST_SHIFT_TO_START_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                       (LAST_SHIFT_TO_START_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // start high time, least
    localparam int CNV_HIGH_NS       = 30;
    localparam int CNV_HIGH_CYC      = (CNV_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // shift clock: least period in ps, and the host's half period in cycles
    localparam int SCK_PERIOD_MIN_PS = 15600;
    localparam int SCK_HALF_CYC      = 4;
    // extra quiet cycles that cover both synchronisers
    localparam int LINK_MARGIN_CYC   = 4;
    // host side buffer depth
    localparam int FIFO_DEPTH        = 16;
    // mode select codes
    localparam logic [1:0] MODE_CMOS    = 2'h0;
    localparam logic [1:0] MODE_LVDS    = 2'h1;
    localparam logic [1:0] MODE_LP_LVDS = 2'h2;
    // reset values of link pins
    localparam logic CNV_IDLE         = 1'h1;
    localparam logic SCK_IDLE         = 1'h0;
    // state sets
    typedef enum logic [1:0] {D_IDLE, D_CONV, D_SHIFT} sadc_dev_st_e;
    typedef enum logic [1:0] {H_IDLE, H_QUIET, H_SHIFT, H_HIGH} sadc_host_st_e;
endpackage

// ==== hw/sadc_if.sv ====
`timescale 1ns/1ps
// serial readout link between converter and reader
interface sadc_if;
    logic       convert_start_n;  // active low start, from host
    logic       sck_p;            // shift clock, positive
    logic       sck_n;            // shift clock, negative
    logic       sck_n_oe;         // host drives sck_n
    logic       sdo_p;            // serial data, positive
    logic       sdo_p_oe;         // device drives sdo_p
    logic       sdo_n;            // serial data, negative
    logic       sdo_n_oe;         // device drives sdo_n
    logic [1:0] io_mode;          // strap, tied by the board

    modport dev (
        input  convert_start_n,
        input  sck_p,
        input  sck_n,
        input  io_mode,
        output sdo_p,
        output sdo_p_oe,
        output sdo_n,
        output sdo_n_oe
    );

    modport host (
        output convert_start_n,
        output sck_p,
        output sck_n,
        output sck_n_oe,
        input  sdo_p,
        input  sdo_p_oe,
        input  sdo_n,
        input  sdo_n_oe,
        input  io_mode
    );
endinterface

// ==== hw/sadc_dev.sv ====
`timescale 1ns/1ps
// converter end: captures a code at start fall, shifts it out on the link
module sadc_dev
    import sadc_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC  // conversion length in cycles
) (
    sadc_if.dev                        link,
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic [WORD_BITS-1:0]  sample_code,
    output logic                       conv_start,
    output logic                       conv_done,
    output logic                       conv_busy,
    output logic                       low_power
);

    // all state of the converter end
    typedef struct packed {
        logic                 cnv_s1;    // start pin, first stage
        logic                 cnv_s2;    // start pin, second stage
        logic                 cnv_d;     // start pin, last level seen
        logic                 sck_s1;    // clock pin, first stage
        logic                 sck_s2;    // clock pin, second stage
        logic                 sck_d;     // clock pin, last level seen
        logic [1:0]           mode_s1;   // mode strap, first stage
        logic [1:0]           mode_s2;   // mode strap, second stage
        sadc_dev_st_e         st;        // phase
        logic [3:0]           cnt;       // conversion countdown
        logic [WORD_BITS-1:0] shreg;     // word being shifted
        logic                 sdo;       // positive data bit
        logic                 sdo_n;     // complement data bit
        logic                 oe;        // positive pin driven
        logic                 oe_n;      // negative pin driven
        logic                 start_p;   // start seen pulse
        logic                 done_p;    // conversion finished pulse
    } sadc_dev_s;

    sadc_dev_s r_reg;   // registered state
    sadc_dev_s r_next;  // next state

    logic cnv_fall;  // start pin went low
    logic sck_fall;  // shift clock went low
    logic diff_on;   // pair mode selected

    // edge finders only look at settled stages, never the first
    assign cnv_fall = r_reg.cnv_d & ~r_reg.cnv_s2;
    assign sck_fall = r_reg.sck_d & ~r_reg.sck_s2;

    // any mode other than cmos uses the negative pin as well
    assign diff_on = (r_reg.mode_s2 != MODE_CMOS);

    // next state
    always_comb begin
        r_next = r_reg;

        // synchronisers for everything that comes from the pins
        r_next.cnv_s1  = link.convert_start_n;
        r_next.cnv_s2  = r_reg.cnv_s1;
        r_next.cnv_d   = r_reg.cnv_s2;
        r_next.sck_s1  = link.sck_p;
        r_next.sck_s2  = r_reg.sck_s1;
        r_next.sck_d   = r_reg.sck_s2;
        r_next.mode_s1 = link.io_mode;
        r_next.mode_s2 = r_reg.mode_s1;

        // pulses last one cycle
        r_next.start_p = 1'b0;
        r_next.done_p  = 1'b0;

        // the start high path never looks at the mode strap; the start fall path uses it for the negative pin
        if (r_reg.cnv_s2) begin
            // start high: drop the pins at once, any word left is lost
            r_next.st   = D_IDLE;
            r_next.oe   = 1'b0;
            r_next.oe_n = 1'b0;
            r_next.cnt  = 4'h0;
        end else begin
            case (r_reg.st)
                D_IDLE: begin
                    // only a real fall starts work; low after reset counts as one
                    if (cnv_fall) begin
                        r_next.st      = D_CONV;
                        r_next.cnt     = 4'(CONV_CYCLES - 1);
                        r_next.shreg   = sample_code;
                        r_next.oe      = 1'b1;
                        r_next.oe_n    = diff_on;
                        r_next.sdo     = 1'b0;
                        r_next.sdo_n   = 1'b1;
                        r_next.start_p = 1'b1;
                    end
                end
                D_CONV: begin
                    // shift clock edges here are ignored: result not ready
                    if (r_reg.cnt == 4'h0) begin
                        r_next.st     = D_SHIFT;
                        r_next.sdo    = r_reg.shreg[WORD_MSB];
                        r_next.sdo_n  = ~r_reg.shreg[WORD_MSB];
                        r_next.done_p = 1'b1;
                    end else begin
                        r_next.cnt = r_reg.cnt - 4'h1;
                    end
                end
                D_SHIFT: begin
                    // each fall brings the next lower bit; zeros follow the word
                    if (sck_fall) begin
                        r_next.shreg = {r_reg.shreg[WORD_MSB-1:0], 1'b0};
                        r_next.sdo   = r_reg.shreg[WORD_MSB-1];
                        r_next.sdo_n = ~r_reg.shreg[WORD_MSB-1];
                    end
                end
                default: begin
                    // stray code: go quiet
                    r_next.st   = D_IDLE;
                    r_next.oe   = 1'b0;
                    r_next.oe_n = 1'b0;
                end
            endcase
        end
    end

    // state register; pins idle as an undriven link with start high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg.cnv_s1  <= CNV_IDLE;
            r_reg.cnv_s2  <= CNV_IDLE;
            r_reg.cnv_d   <= CNV_IDLE;
            r_reg.sck_s1  <= SCK_IDLE;
            r_reg.sck_s2  <= SCK_IDLE;
            r_reg.sck_d   <= SCK_IDLE;
            r_reg.mode_s1 <= MODE_CMOS;
            r_reg.mode_s2 <= MODE_CMOS;
            r_reg.st      <= D_IDLE;
            r_reg.cnt     <= 4'h0;
            r_reg.shreg   <= '0;
            r_reg.sdo     <= 1'b0;
            r_reg.sdo_n   <= 1'b1;
            r_reg.oe      <= 1'b0;
            r_reg.oe_n    <= 1'b0;
            r_reg.start_p <= 1'b0;
            r_reg.done_p  <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    // pins: data and enables straight from flip-flops
    assign link.sdo_p    = r_reg.sdo;
    assign link.sdo_p_oe = r_reg.oe;
    // negative pin only in pair modes; cmos leaves it alone
    assign link.sdo_n    = r_reg.sdo_n;
    assign link.sdo_n_oe = r_reg.oe_n;

    // user side status
    assign conv_start = r_reg.start_p;
    assign conv_done  = r_reg.done_p;
    assign conv_busy  = (r_reg.st != D_IDLE);
    // low power pair mode only changes swing, not logic
    assign low_power  = (r_reg.mode_s2 == MODE_LP_LVDS);

endmodule

// ==== hw/sadc_host.sv ====
`timescale 1ns/1ps
// word buffer; depth must be a power of two
module sadc_fifo #(
    parameter int WIDTH = 15,  // word width
    parameter int DEPTH = 16   // words held
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    // pointers carry one wrap bit to tell full from empty
    typedef struct packed {
        logic [AW:0] wp;  // write pointer
        logic [AW:0] rp;  // read pointer
    } sadc_fifo_s;

    sadc_fifo_s       r_reg;          // pointers
    sadc_fifo_s       r_next;         // next pointers
    logic [WIDTH-1:0] mem [DEPTH];    // storage
    logic             wr;             // write taken
    logic             rd;             // read taken

    assign out_valid = (r_reg.wp != r_reg.rp);
    assign in_ready  = !((r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]));
    assign wr        = in_valid & in_ready;
    assign rd        = out_valid & out_ready;
    assign out_data  = mem[r_reg.rp[AW-1:0]];

    // pointer update; a write and a read in one cycle move both pointers
    always_comb begin
        r_next = r_reg;
        if (wr) begin
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (rd) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
    end

    // pointer register; reset empties the buffer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // storage needs no reset, reads are gated by out_valid
    always_ff @(posedge clk) begin
        if (wr) begin
            mem[r_reg.wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// reader end: starts conversions, makes the shift clock, collects words
module sadc_host
    import sadc_pkg::*;
#(
    parameter int SCK_HALF   = SCK_HALF_CYC,               // half shift period in cycles
    parameter int QUIET      = QUIET_CYC + LINK_MARGIN_CYC, // wait before first edge
    parameter int DEPTH      = FIFO_DEPTH                   // buffered words
) (
    sadc_if.host                       link,  // reader side of the link
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  start,
    output logic                       busy,
    output logic                       word_valid,
    input  wire logic                  word_ready,
    output logic [WORD_BITS-1:0]       word_data
);
    // all state of the reader end
    typedef struct packed {
        sadc_host_st_e        st;       // phase
        logic [7:0]           cnt;      // phase countdown
        logic [3:0]           bitn;     // bits still to take
        logic                 sck;      // shift clock level
        logic                 cnv_n;    // start pin level
        logic [WORD_BITS-1:0] word;     // assembled word
        logic                 push;     // word ready for buffer
        logic                 sdo_s1;   // data pin, first stage
        logic                 sdo_s2;   // data pin, second stage
        logic [1:0]           mode_s1;  // strap, first stage
        logic [1:0]           mode_s2;  // strap, second stage
    } sadc_host_s;

    sadc_host_s r_reg;     // registered state
    sadc_host_s r_next;    // next state
    logic       room;      // buffer can take a word

    // next state
    always_comb begin
        r_next         = r_reg;
        r_next.sdo_s1  = link.sdo_p;
        r_next.sdo_s2  = r_reg.sdo_s1;
        r_next.mode_s1 = link.io_mode;
        r_next.mode_s2 = r_reg.mode_s1;
        r_next.push    = 1'b0;
        case (r_reg.st)
            H_IDLE: begin
                // no start without room: a full buffer stalls the link
                if (start && room && !r_reg.push) begin
                    r_next.st    = H_QUIET;
                    r_next.cnv_n = 1'b0;
                    r_next.cnt   = 8'(QUIET - 1);
                end
            end
            H_QUIET: begin
                // clock held still while the converter works
                if (r_reg.cnt == 8'h0) begin
                    r_next.st   = H_SHIFT;
                    r_next.sck  = 1'b1;
                    r_next.cnt  = 8'(SCK_HALF - 1);
                    r_next.bitn = 4'(WORD_BITS - 1);
                end else begin
                    r_next.cnt = r_reg.cnt - 8'h1;
                end
            end
            H_SHIFT: begin
                if (r_reg.cnt == 8'h0) begin
                    r_next.cnt = 8'(SCK_HALF - 1);
                    r_next.sck = ~r_reg.sck;
                    if (r_reg.sck) begin
                        // taking the bit as the clock falls
                        r_next.word = {r_reg.word[WORD_MSB-1:0], r_reg.sdo_s2};
                        if (r_reg.bitn == 4'h0) begin
                            // start rises on the last fall, never before
                            r_next.st    = H_HIGH;
                            r_next.cnv_n = 1'b1;
                            r_next.push  = 1'b1;
                            r_next.cnt   = 8'(CNV_HIGH_CYC - 1);
                        end else begin
                            r_next.bitn = r_reg.bitn - 4'h1;
                        end
                    end
                end else begin
                    r_next.cnt = r_reg.cnt - 8'h1;
                end
            end
            H_HIGH: begin
                // start high time before the next conversion
                if (r_reg.cnt == 8'h0) begin
                    r_next.st = H_IDLE;
                end else begin
                    r_next.cnt = r_reg.cnt - 8'h1;
                end
            end
            default: r_next.st = H_IDLE;
        endcase
    end

    // state register; the link idles with start high and clock low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg.st      <= H_IDLE;
            r_reg.cnt     <= 8'h0;
            r_reg.bitn    <= 4'h0;
            r_reg.sck     <= SCK_IDLE;
            r_reg.cnv_n   <= CNV_IDLE;
            r_reg.word    <= '0;
            r_reg.push    <= 1'b0;
            r_reg.sdo_s1  <= 1'b0;
            r_reg.sdo_s2  <= 1'b0;
            r_reg.mode_s1 <= MODE_CMOS;
            r_reg.mode_s2 <= MODE_CMOS;
        end else begin
            r_reg <= r_next;
        end
    end

    // pins; cmos leaves the negative clock undriven
    assign link.convert_start_n = r_reg.cnv_n;
    assign link.sck_p           = r_reg.sck;
    assign link.sck_n           = ~r_reg.sck;
    assign link.sck_n_oe        = (r_reg.mode_s2 != MODE_CMOS);
    assign busy                 = (r_reg.st != H_IDLE) | r_reg.push;

    sadc_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(DEPTH)
    ) sadc_fifo_inst (
        .clk      (clk),
        .resetn   (resetn),
        .in_valid (r_reg.push),
        .in_ready (room),
        .in_data  (r_reg.word),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data (word_data)
    );
endmodule

// ==== test/sadc_link_sva.sv ====
`timescale 1ns/1ps
// watches the link that joins the converter end to the reader end
module sadc_link_sva
    import sadc_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       convert_start_n,
    input wire logic       sck_p,
    input wire logic       sck_n,
    input wire logic       sck_n_oe,
    input wire logic       sdo_p,
    input wire logic       sdo_p_oe,
    input wire logic       sdo_n,
    input wire logic       sdo_n_oe,
    input wire logic [1:0] io_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [4:0] falls_reg; // shift falls seen in this frame
    // count falls per frame; start high clears it, so an abort leaves no residue
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            falls_reg <= 5'h0;
        else if (convert_start_n)
            falls_reg <= 5'h0;
        else if ($fell(sck_p))
            falls_reg <= falls_reg + 5'h1;
    end
    chk_drive_after_fall: assert property ($fell(convert_start_n) |-> ##[1:6] sdo_p_oe)
        else $error("data line not driven after start fall");
    chk_release_after_rise: assert property ($rose(convert_start_n) |-> ##[1:5] !sdo_p_oe)
        else $error("data line not released after start rise");
    chk_idle_released: assert property (convert_start_n [*6] |-> !sdo_p_oe && !sdo_n_oe)
        else $error("data line driven while idle");
    chk_quiet_after_fall: assert property ($fell(convert_start_n) |-> !sck_p [*6])
        else $error("shift clock moved inside the quiet time");
    chk_sck_high_min: assert property ($rose(sck_p) |-> sck_p [*4])
        else $error("shift clock high phase too short");
    chk_sck_low_min: assert property ($fell(sck_p) && !convert_start_n |-> !sck_p [*4])
        else $error("shift clock low phase too short");
    chk_word_fall_count: assert property ($rose(convert_start_n) |-> $fell(sck_p) && falls_reg == 5'he)
        else $error("frame did not end on the fifteenth shift fall");
    chk_sck_idle_low: assert property (convert_start_n |-> !sck_p)
        else $error("shift clock high while start is high");
    chk_data_pair: assert property (sdo_n_oe |-> sdo_p_oe && (sdo_n == !sdo_p))
        else $error("data pair not complementary");
    chk_clock_pair: assert property (sck_n_oe |-> sck_n == !sck_p)
        else $error("clock pair not complementary");
    chk_cmos_single: assert property ((io_mode == MODE_CMOS) [*6] |-> !sdo_n_oe && !sck_n_oe)
        else $error("negative pins driven in single ended style");
    chk_lvds_pair: assert property ((io_mode != MODE_CMOS) [*6] |-> sck_n_oe && (sdo_n_oe == sdo_p_oe))
        else $error("pair not driven in differential style");
    cov_frame_end: cover property ($rose(convert_start_n));
    cov_low_power: cover property ((io_mode == MODE_LP_LVDS) && sdo_n_oe);
    cov_idle: cover property (convert_start_n [*8]);
endmodule

// ==== test/sar_adc_serial_readout_bench.sv ====
`timescale 1ns/1ps
// both ends joined, plus a lone converter end driven by hand for fault cases
module sar_adc_serial_readout_bench;
    import sadc_pkg::*;
    localparam logic [WORD_BITS-1:0] CODES [8] = '{15'h4000, 15'h3fff, 15'h0000, 15'h7fff,
                                                   15'h0001, 15'h2aaa, 15'h5555, 15'h7ffe};
    localparam logic [1:0]           MODES [3] = '{MODE_CMOS, MODE_LVDS, MODE_LP_LVDS};
    logic                 clk;          // local clock
    logic                 resetn;       // active low reset
    logic                 start;        // conversion request to the reader
    logic                 word_ready;   // bench takes words
    logic [WORD_BITS-1:0] sample_code;  // code for the joined converter
    logic [WORD_BITS-1:0] code2;        // code for the lone converter
    logic                 busy;         // reader busy
    logic                 word_valid;   // word waiting in the buffer
    logic [WORD_BITS-1:0] word_data;    // head word
    logic                 conv_start;   // capture pulse
    logic                 conv_done;    // first bit on the line
    logic                 conv_busy;    // converter busy
    logic                 low_power;    // low power style seen
    logic                 conv_done2;   // lone converter ready
    logic [WORD_BITS-1:0] exp_q[$];     // captured codes for the reader side
    logic [WORD_BITS-1:0] wire_q[$];    // captured codes for the wire watch
    logic [WORD_BITS-1:0] mon_reg;      // bits gathered off the data line
    logic [WORD_BITS-1:0] mon_next;
    logic                 sck_prev;     // shift clock one sample back
    logic                 cnv_prev;     // start one sample back
    logic [2:0]           code_idx;     // next entry of the code table
    int                   err_total;
    int                   num_checks;
    int                   frames;       // conversions captured
    int                   n;            // wait bound
    sadc_if link();
    sadc_if link2();
    // the lone end's clock pair is made here; a lone end has no reader
    assign link2.sck_n = ~link2.sck_p;
    assign link2.sck_n_oe = 1'h1;
    sadc_dev sadc_dev_inst (.link(link), .clk(clk), .resetn(resetn), .sample_code(sample_code),
        .conv_start(conv_start), .conv_done(conv_done), .conv_busy(conv_busy), .low_power(low_power));
    sadc_host sadc_host_inst (.link(link), .clk(clk), .resetn(resetn), .start(start), .busy(busy),
        .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
    sadc_dev sadc_dev_inst2 (.link(link2), .clk(clk), .resetn(resetn), .sample_code(code2),
        .conv_start(), .conv_done(conv_done2), .conv_busy(), .low_power());
    sadc_link_sva sadc_link_sva_inst (.clk(clk), .resetn(resetn), .convert_start_n(link.convert_start_n),
        .sck_p(link.sck_p), .sck_n(link.sck_n), .sck_n_oe(link.sck_n_oe), .sdo_p(link.sdo_p),
        .sdo_p_oe(link.sdo_p_oe), .sdo_n(link.sdo_n), .sdo_n_oe(link.sdo_n_oe), .io_mode(link.io_mode));
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // wait for a word, compare with the oldest capture, take it with a one cycle ready
    task automatic read_word();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (word_valid !== 1'h1 && k < 400);
        check("word_valid", 16'(word_valid), 16'h1);
        check("word_data", 16'(word_data), 16'(exp_q.size() > 0 ? exp_q.pop_front() : 15'h0));
        word_ready = 1'h1;
        @(posedge clk);
        #1 word_ready = 1'h0;
    endtask
    // wait until the reader goes idle, then let both synchronisers settle
    task automatic wait_idle();
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (busy !== 1'h0 && n < 400);
        repeat (8) @(posedge clk);
        #1;
    endtask
    // note each captured code, then move the input on; codes cover sign boundaries
    always @(posedge clk) begin
        if (conv_start === 1'h1) begin
            exp_q.push_back(sample_code);
            wire_q.push_back(sample_code);
            frames++;
            code_idx <= #1 code_idx + 3'h1;
            sample_code <= #1 CODES[code_idx + 3'h1];
        end
        // the first bit shows with the done pulse while the converter is still busy
        if (conv_done === 1'h1 && wire_q.size() > 0)
            check("first bit", 16'({conv_busy, link.sdo_p}), 16'({1'h1, wire_q[0][WORD_MSB]}));
    end
    // gather the data line at each shift fall; judge the word when start rises
    always @(posedge clk) begin
        mon_next = (sck_prev && !link.sck_p) ? {mon_reg[WORD_MSB-1:0], link.sdo_p} : mon_reg;
        if (resetn && !cnv_prev && link.convert_start_n && wire_q.size() > 0)
            check("sdo word", 16'(mon_next), 16'(wire_q.pop_front()));
        mon_reg <= mon_next;
        sck_prev <= link.sck_p;
        cnv_prev <= link.convert_start_n;
    end
    // a hang ends the run through the same closing task
    initial begin
        #(CLK_PERIOD_NS * 30000);
        err_total++;
        finish_test();
    end
    initial begin
        clk = 1'h0;
        resetn = 1'h0;
        start = 1'h0;
        word_ready = 1'h0;
        code2 = 15'h5a5a;
        code_idx = 3'h0;
        sample_code = CODES[0];
        mon_reg = 15'h0;
        sck_prev = 1'h0;
        cnv_prev = 1'h1;
        err_total = 0;
        num_checks = 0;
        frames = 0;
        link.io_mode = MODE_CMOS;
        link2.io_mode = MODE_LVDS;
        link2.convert_start_n = CNV_IDLE;
        link2.sck_p = SCK_IDLE;
        repeat (16) @(posedge clk);
        #1 resetn = 1'h1;
        // every signalling style, words back to back
        for (int m = 0; m < 3; m++) begin
            link.io_mode = MODES[m];
            repeat (8) @(posedge clk);
            #1 check("low_power", 16'(low_power), 16'(MODES[m] == MODE_LP_LVDS));
            start = 1'h1;
            repeat (3) read_word();
            start = 1'h0;
            wait_idle();
            while (exp_q.size() > 0) read_word();
        end
        // reader stalled: buffer fills and refuses, then drains to empty
        frames = 0;
        start = 1'h1;
        repeat (20 * 150) @(posedge clk);
        #1 check("frames when full", 16'(frames), 16'(FIFO_DEPTH));
        check("busy when full", 16'({busy, conv_busy}), 16'h0);
        start = 1'h0;
        repeat (FIFO_DEPTH) read_word();
        repeat (4) @(posedge clk);
        #1 check("word_valid empty", 16'(word_valid), 16'h0);
        // lone end: stray shift edge inside the conversion, then an abort mid word
        link2.convert_start_n = 1'h0;
        repeat (4) @(posedge clk);
        #1 link2.sck_p = 1'h1;
        @(posedge clk);
        #1 link2.sck_p = 1'h0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (conv_done2 !== 1'h1 && n < 40);
        check("drive", 16'(link2.sdo_p_oe), 16'h1);
        for (int i = WORD_MSB; i >= 7; i--) begin
            check("sdo pair", 16'({link2.sdo_p, link2.sdo_n}), 16'({code2[i], ~code2[i]}));
            link2.sck_p = 1'h1;
            repeat (3) @(posedge clk);
            #1 link2.sck_p = 1'h0;
            repeat (5) @(posedge clk);
            #1;
        end
        link2.convert_start_n = 1'h1;
        repeat (5) @(posedge clk);
        #1 check("release", 16'(link2.sdo_p_oe), 16'h0);
        finish_test();
    end
endmodule
